// *** shared/pcg_pkg.sv ***
// package for the peripheral clock gating block: register map, field layout, modes
// assumes a 16-bit register port addressed by word index, one mclk domain
package pcg_pkg;
  localparam int unsigned AW = 8;               // register address width
  localparam int unsigned DW = 16;              // register data width

  // device registers, word index
  localparam logic [7:0] PCG_RATE_OFS   = 8'h0B;   // periph_clock_rate_select
  localparam logic [7:0] PCG_PCE_LO_OFS = 8'h0C;   // periph_clock_enable_low
  localparam logic [7:0] PCG_PCE_HI_OFS = 8'h0D;   // periph_clock_enable_high
  localparam logic [7:0] PCG_SD_LO_OFS  = 8'h0E;   // stop_keep_clock_low
  // controller registers seen by software on the controller's own port
  localparam logic [7:0] PCG_RUN_LO_OFS = 8'h20;   // peripheral run request, low group
  localparam logic [7:0] PCG_RUN_HI_OFS = 8'h21;   // peripheral run request, high group
  localparam logic [7:0] PCG_STOP_OFS   = 8'h22;   // stop request and stop status

  // reset values
  localparam logic [15:0] PCG_RST_VAL   = 16'h0000;

  // writable bit masks; reserved bits store and read as zero
  localparam logic [15:0] PCG_RATE_MASK = 16'h7000;
  localparam logic [15:0] PCG_LO_MASK   = 16'hF455;
  localparam logic [15:0] PCG_HI_MASK   = 16'h100F;

  // rate select bit positions
  localparam int unsigned TIMER_RATE_BIT = 14;   // timer_rate_sel
  localparam int unsigned PWM_RATE_BIT   = 13;   // pulse_mod_rate_sel
  localparam int unsigned TWI_RATE_BIT   = 12;   // two_wire_rate_sel

  // low group clock enable positions
  localparam int unsigned COMPARATOR_B_CLK_EN_BIT  = 15;        // comparator_b_clk_en
  localparam int unsigned COMPARATOR_A_CLK_EN_BIT  = 14;        // comparator_a_clk_en
  localparam int unsigned CONV1_BIT = 13;        // converter_out1_clk_en
  localparam int unsigned CONV0_BIT = 12;        // converter_out0_clk_en
  localparam int unsigned ADC_BIT   = 10;        // analog in clock enable
  localparam int unsigned TWI_BIT   = 6;         // two-wire clock enable
  localparam int unsigned ASER_BIT  = 4;         // async_serial_clk_en
  localparam int unsigned SSER_BIT  = 2;         // sync_serial_clk_en
  localparam int unsigned PWM_BIT   = 0;         // pulse-width clock enable
  // high group clock enable positions
  localparam int unsigned PIT_BIT   = 12;        // interval_timer_clk_en
  localparam logic [15:0] TIMER_CH_MASK = 16'h000F;  // timer_ch3..0_clk_en

  // stop control register fields
  localparam int unsigned STOP_REQ_BIT = 0;      // write 1: enter stop; read: stop status

  // system power mode
  typedef enum logic {
    PCG_RUN  = 1'b0,
    PCG_STOP = 1'b1
  } pcg_mode_t;
endpackage : pcg_pkg

// *** shared/pcg_if.sv ***
// interface joining the controller end and the clock gating device end
// assumes both ends run on the same mclk; all signals are plain levels or strobes
interface pcg_if;
  import pcg_pkg::*;
  logic            wr;        // register write strobe
  logic [AW-1:0]   wr_addr;   // register write index
  logic [DW-1:0]   wdata;     // register write data
  logic            rd;        // register read strobe
  logic [AW-1:0]   rd_addr;   // register read index
  logic [DW-1:0]   rdata;     // read data, cycle after rd
  logic            stop_req;  // one-cycle request to enter stop
  logic            stop_mode; // system is in stop mode

  modport dev  (input wr, wr_addr, wdata, rd, rd_addr, stop_req, output rdata, stop_mode);
  modport host (output wr, wr_addr, wdata, rd, rd_addr, stop_req, input rdata, stop_mode);
endinterface : pcg_if

// *** logic/pcg_clock_gate.sv ***
// clock gating device end: rate select, clock enables, stop-keep bits, run/stop mode
// assumes synchronous inputs on mclk; gated clocks are delivered as registered enables
// How it works
// - timer rate bit: 0 system clock, 1 triple
// - pulse-width rate bit picks system or triple
// - two-wire rate bit picks system or triple
// - software writes zero to reserved bits
// - disabled peripheral stopped, its accesses ignored
// - software disables peripheral before clock off
// - stop gates enabled clocks unless keep set
// - low enable register maps nine peripheral clocks
// - high enable: interval timer, timer channels
// - after reset all clocks off in stop
// - keep bit works only with clock enable
// - running peripheral interrupt returns to run
// - software keeps few peripherals running in stop
// - software disables non-kept peripherals before stop
// - triple rate only when loop drives clock
// - software disables peripheral before rate change
module pcg_clock_gate
  import pcg_pkg::*;
(
  input  wire logic        mclk,            // system clock
  input  wire logic        rst_n,           // synchronous reset, active low
  pcg_if.dev               bus,             // register port and mode link
  input  wire logic        pll_active,      // loop output is the system clock
  input  wire logic [15:0] irq_lo,          // interrupts from low group peripherals
  input  wire logic [15:0] irq_hi,          // interrupts from high group peripherals
  output logic      [15:0] clk_gate_lo,     // clock enables, low group
  output logic      [15:0] clk_gate_hi,     // clock enables, high group
  output logic      [15:0] access_ok_lo,    // bus access allowed, low group
  output logic      [15:0] access_ok_hi,    // bus access allowed, high group
  output logic             timer_fast,      // timer runs on triple rate
  output logic             pwm_fast,        // pulse-width runs on triple rate
  output logic             two_wire_fast    // two-wire run clock on triple rate
);

  // whole state of the device end
  typedef struct packed {
    logic [15:0] rate;      // periph_clock_rate_select
    logic [15:0] pce_lo;    // periph_clock_enable_low
    logic [15:0] pce_hi;    // periph_clock_enable_high
    logic [15:0] sd_lo;     // stop_keep_clock_low
    pcg_mode_t   mode;      // run or stop
    logic [15:0] gate_lo;   // registered clock enables
    logic [15:0] gate_hi;
    logic [2:0]  fast;      // timer, pulse-width, two-wire triple rate
    logic [15:0] rdata;     // read data register
  } pcg_dev_t;

  pcg_dev_t state_reg;      // current state
  pcg_dev_t state_next;     // next state

  // next-state logic
  always_comb begin
    state_next       = state_reg;
    state_next.rdata = PCG_RST_VAL;
    // register writes; reserved bits are dropped
    if (bus.wr) begin
      unique case (bus.wr_addr)
        PCG_RATE_OFS:   state_next.rate   = bus.wdata & PCG_RATE_MASK;
        PCG_PCE_LO_OFS: state_next.pce_lo = bus.wdata & PCG_LO_MASK;
        PCG_PCE_HI_OFS: state_next.pce_hi = bus.wdata & PCG_HI_MASK;
        PCG_SD_LO_OFS:  state_next.sd_lo  = bus.wdata & PCG_LO_MASK;
        default: ;                        // unmapped: ignored
      endcase
    end
    // register reads, answered in the next cycle; unmapped reads zero
    if (bus.rd) begin
      unique case (bus.rd_addr)
        PCG_RATE_OFS:   state_next.rdata = state_reg.rate;
        PCG_PCE_LO_OFS: state_next.rdata = state_reg.pce_lo;
        PCG_PCE_HI_OFS: state_next.rdata = state_reg.pce_hi;
        PCG_SD_LO_OFS:  state_next.rdata = state_reg.sd_lo;
        default:        state_next.rdata = PCG_RST_VAL;
      endcase
    end
    // run/stop mode
    unique case (state_reg.mode)
      PCG_RUN: begin
        if (bus.stop_req) begin
          state_next.mode = PCG_STOP;
        end
      end
      PCG_STOP: begin
        // an interrupt from a peripheral still clocked wakes the system
        if (|(irq_lo & state_reg.gate_lo) || |(irq_hi & state_reg.gate_hi)) begin
          state_next.mode = PCG_RUN;
        end
      end
    endcase
    // clock gates: enable bit, and in stop only with its keep bit
    if (state_next.mode == PCG_RUN) begin
      state_next.gate_lo = state_next.pce_lo;
      state_next.gate_hi = state_next.pce_hi;
    end else begin
      state_next.gate_lo = state_next.pce_lo & state_next.sd_lo;
      state_next.gate_hi = PCG_RST_VAL;
    end
    // triple rate needs the loop as system clock
    state_next.fast[2] = state_next.rate[TIMER_RATE_BIT] & pll_active;
    state_next.fast[1] = state_next.rate[PWM_RATE_BIT] & pll_active;
    state_next.fast[0] = state_next.rate[TWI_RATE_BIT] & pll_active;
  end

  // state register; every gate and rate output comes from here, so no runt pulses
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg.rate    <= PCG_RST_VAL;
      state_reg.pce_lo  <= PCG_RST_VAL;
      state_reg.pce_hi  <= PCG_RST_VAL;
      state_reg.sd_lo   <= PCG_RST_VAL;
      state_reg.mode    <= PCG_RUN;
      state_reg.gate_lo <= PCG_RST_VAL;
      state_reg.gate_hi <= PCG_RST_VAL;
      state_reg.fast    <= 3'h0;
      state_reg.rdata   <= PCG_RST_VAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign bus.rdata      = state_reg.rdata;
  assign bus.stop_mode  = (state_reg.mode == PCG_STOP);
  assign clk_gate_lo    = state_reg.gate_lo;
  assign clk_gate_hi    = state_reg.gate_hi;
  assign access_ok_lo   = state_reg.gate_lo;
  assign access_ok_hi   = state_reg.gate_hi;
  assign timer_fast     = state_reg.fast[2];
  assign pwm_fast       = state_reg.fast[1];
  assign two_wire_fast  = state_reg.fast[0];

endmodule // pcg_clock_gate

// *** logic/pcg_controller.sv ***
// controller end: software port, peripheral enables, sequenced writes to the device
// assumes the device answers reads one cycle later and takes writes at once
//
// Strobed register access was chosen for this implementation.
module pcg_controller
  import pcg_pkg::*;
(
  input  wire logic          mclk,        // system clock
  input  wire logic          rst_n,       // synchronous reset, active low
  pcg_if.host                bus,         // link to the clock gating device
  input  wire logic [AW-1:0] sw_addr,     // software register index
  input  wire logic [DW-1:0] sw_wdata,    // software write data
  input  wire logic          sw_wr,       // software write strobe
  input  wire logic          sw_rd,       // software read strobe
  output logic      [DW-1:0] sw_rdata,    // software read data, cycle after sw_rd
  output logic      [15:0]   periph_en_lo, // peripheral own enables, low group
  output logic      [15:0]   periph_en_hi  // peripheral own enables, high group
);

  // whole state of the controller end
  typedef struct packed {
    logic [15:0]   rate;      // shadow of device rate register
    logic [15:0]   pce_lo;    // shadow of device enables
    logic [15:0]   pce_hi;
    logic [15:0]   sd_lo;     // shadow of device keep bits
    logic [15:0]   run_lo;    // software run requests
    logic [15:0]   run_hi;
    logic [15:0]   en_lo;     // peripheral enables driven out
    logic [15:0]   en_hi;
    logic          pend_wr;   // write to forward next cycle
    logic [AW-1:0] pend_addr;
    logic [DW-1:0] pend_data;
    logic          pend_stop; // stop request to forward next cycle
    logic          own_rd;    // last read hit a controller register
    logic [DW-1:0] own_rdata;
  } pcg_host_t;

  pcg_host_t state_reg;       // current state
  pcg_host_t state_next;      // next state

  // next-state logic
  always_comb begin
    logic [15:0] quiet_lo;    // enables to drop before the device change
    logic [15:0] quiet_hi;
    logic [15:0] keep_lo;     // enables allowed by the power mode
    logic [15:0] keep_hi;
    logic [15:0] wmask;       // write data with reserved bits cleared
    quiet_lo             = 16'h0000;
    quiet_hi             = 16'h0000;
    keep_lo              = 16'hFFFF;
    keep_hi              = 16'hFFFF;
    wmask                = 16'h0000;
    state_next           = state_reg;
    state_next.pend_wr   = 1'b0;
    state_next.pend_stop = 1'b0;
    state_next.own_rd    = 1'b0;
    if (sw_wr) begin
      state_next.pend_addr = sw_addr;
      unique case (sw_addr)
        PCG_RATE_OFS: begin
          wmask = sw_wdata & PCG_RATE_MASK;
          // quiet every peripheral whose rate changes
          if (wmask[TIMER_RATE_BIT] != state_reg.rate[TIMER_RATE_BIT]) begin
            quiet_hi = TIMER_CH_MASK;
          end
          quiet_lo[PWM_BIT] = wmask[PWM_RATE_BIT] ^ state_reg.rate[PWM_RATE_BIT];
          quiet_lo[TWI_BIT] = wmask[TWI_RATE_BIT] ^ state_reg.rate[TWI_RATE_BIT];
          state_next.rate    = wmask;
          state_next.pend_wr = 1'b1;
        end
        PCG_PCE_LO_OFS: begin
          wmask               = sw_wdata & PCG_LO_MASK;
          quiet_lo            = state_reg.pce_lo & ~wmask;
          state_next.pce_lo   = wmask;
          state_next.pend_wr  = 1'b1;
        end
        PCG_PCE_HI_OFS: begin
          wmask               = sw_wdata & PCG_HI_MASK;
          quiet_hi            = state_reg.pce_hi & ~wmask;
          state_next.pce_hi   = wmask;
          state_next.pend_wr  = 1'b1;
        end
        PCG_SD_LO_OFS: begin
          wmask               = sw_wdata & PCG_LO_MASK;
          // dropping a keep bit while stopped stops that clock
          if (bus.stop_mode) begin
            quiet_lo = state_reg.sd_lo & ~wmask;
          end
          state_next.sd_lo    = wmask;
          state_next.pend_wr  = 1'b1;
        end
        PCG_RUN_LO_OFS: state_next.run_lo = sw_wdata & PCG_LO_MASK;
        PCG_RUN_HI_OFS: state_next.run_hi = sw_wdata & PCG_HI_MASK;
        PCG_STOP_OFS: begin
          // quiet everything not kept, then ask for stop
          if (sw_wdata[STOP_REQ_BIT] && !bus.stop_mode) begin
            quiet_lo             = ~(state_reg.pce_lo & state_reg.sd_lo);
            quiet_hi             = 16'hFFFF;
            state_next.pend_stop = 1'b1;
          end
        end
        default: ;                        // unmapped: ignored
      endcase
      state_next.pend_data = wmask;
    end
    // controller registers answer reads here; device registers answer on the link
    if (sw_rd) begin
      unique case (sw_addr)
        PCG_RUN_LO_OFS: begin
          state_next.own_rd    = 1'b1;
          state_next.own_rdata = state_reg.run_lo;
        end
        PCG_RUN_HI_OFS: begin
          state_next.own_rd    = 1'b1;
          state_next.own_rdata = state_reg.run_hi;
        end
        PCG_STOP_OFS: begin
          state_next.own_rd    = 1'b1;
          state_next.own_rdata = {15'h0000, bus.stop_mode};
        end
        default: ;                        // forwarded to the device
      endcase
    end
    // in stop, or about to enter it, only kept peripherals may run
    if (bus.stop_mode || state_reg.pend_stop) begin
      keep_lo = state_reg.pce_lo & state_reg.sd_lo;
      keep_hi = 16'h0000;
    end
    // a peripheral runs only while its clock is on; quiet bits fall first
    state_next.en_lo = state_reg.run_lo & state_reg.pce_lo & keep_lo & ~quiet_lo;
    state_next.en_hi = state_reg.run_hi & state_reg.pce_hi & keep_hi & ~quiet_hi;
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg.rate      <= PCG_RST_VAL;
      state_reg.pce_lo    <= PCG_RST_VAL;
      state_reg.pce_hi    <= PCG_RST_VAL;
      state_reg.sd_lo     <= PCG_RST_VAL;
      state_reg.run_lo    <= PCG_RST_VAL;
      state_reg.run_hi    <= PCG_RST_VAL;
      state_reg.en_lo     <= PCG_RST_VAL;
      state_reg.en_hi     <= PCG_RST_VAL;
      state_reg.pend_wr   <= 1'b0;
      state_reg.pend_addr <= 8'h00;
      state_reg.pend_data <= PCG_RST_VAL;
      state_reg.pend_stop <= 1'b0;
      state_reg.own_rd    <= 1'b0;
      state_reg.own_rdata <= PCG_RST_VAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // link outputs: writes one cycle late, reads passed straight through
  assign bus.wr       = state_reg.pend_wr;
  assign bus.wr_addr  = state_reg.pend_addr;
  assign bus.wdata    = state_reg.pend_data;
  assign bus.rd       = sw_rd;
  assign bus.rd_addr  = sw_addr;
  assign bus.stop_req = state_reg.pend_stop;
  assign sw_rdata     = state_reg.own_rd ? state_reg.own_rdata : bus.rdata;
  assign periph_en_lo = state_reg.en_lo;
  assign periph_en_hi = state_reg.en_hi;

endmodule // pcg_controller

// *** testbench/pcg_props.sv ***
// checker for the link between controller and clock gating device: gates, stop, rates
// assumes one mclk domain; the bench instantiates it beside the link interface
module pcg_props
  import pcg_pkg::*;
(
  input wire logic          mclk,          // system clock
  input wire logic          rst_n,         // synchronous reset, active low
  input wire logic          wr,            // device write strobe
  input wire logic [AW-1:0] wr_addr,       // device write index
  input wire logic [DW-1:0] wdata,         // device write data
  input wire logic          stop_req,      // stop request pulse
  input wire logic          stop_mode,     // stop status
  input wire logic          pll_active,    // loop drives the system clock
  input wire logic [15:0]   irq_lo,        // low group interrupts
  input wire logic [15:0]   irq_hi,        // high group interrupts
  input wire logic [15:0]   clk_gate_lo,   // low group clock enables
  input wire logic [15:0]   clk_gate_hi,   // high group clock enables
  input wire logic [15:0]   access_ok_lo,  // low group access allowed
  input wire logic [15:0]   access_ok_hi,  // high group access allowed
  input wire logic          timer_fast,    // timer on triple rate
  input wire logic          pwm_fast,      // pulse-width on triple rate
  input wire logic          two_wire_fast  // two-wire on triple rate
);
  timeunit 1ns;
  timeprecision 1ps;
  // every property samples on mclk and rests while reset is held
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_gate_lo_write: assert property (
    wr && wr_addr == PCG_PCE_LO_OFS && !stop_mode && !stop_req
    |=> clk_gate_lo == ($past(wdata) & PCG_LO_MASK))
    else $error("low gates differ from write");
  a_gate_hi_write: assert property (
    wr && wr_addr == PCG_PCE_HI_OFS && !stop_mode && !stop_req
    |=> clk_gate_hi == ($past(wdata) & PCG_HI_MASK))
    else $error("high gates differ from write");
  a_access_gate: assert property (
    access_ok_lo == clk_gate_lo && access_ok_hi == clk_gate_hi)
    else $error("access permission differs from gate");
  a_stop_hi_off: assert property (
    stop_mode |-> clk_gate_hi == 16'h0000) else $error("high clock running in stop");
  a_keep_needs_en: assert property (
    $rose(stop_mode) |-> (clk_gate_lo & ~$past(clk_gate_lo)) == 16'h0000)
    else $error("stop turned on a disabled clock");
  a_stop_enter: assert property (
    stop_req && !stop_mode |=> stop_mode) else $error("stop not entered");
  a_stop_holds: assert property (
    stop_mode && (irq_lo & clk_gate_lo) == 16'h0000 && (irq_hi & clk_gate_hi) == 16'h0000
    |=> stop_mode) else $error("stop left without wake source");
  a_wake_irq: assert property (
    stop_mode && (irq_lo & clk_gate_lo) != 16'h0000 |=> !stop_mode)
    else $error("running peripheral interrupt did not wake");
  a_timer_rate: assert property (
    wr && wr_addr == PCG_RATE_OFS && pll_active |=> timer_fast == $past(wdata[TIMER_RATE_BIT]))
    else $error("timer rate differs from write");
  a_pwm_rate: assert property (
    wr && wr_addr == PCG_RATE_OFS && pll_active |=> pwm_fast == $past(wdata[PWM_RATE_BIT]))
    else $error("pulse-width rate differs from write");
  a_two_wire_rate: assert property (
    wr && wr_addr == PCG_RATE_OFS && pll_active |=> two_wire_fast == $past(wdata[TWI_RATE_BIT]))
    else $error("two-wire rate differs from write");
  a_no_pll_fast: assert property (
    !$past(pll_active) |-> !timer_fast && !pwm_fast && !two_wire_fast)
    else $error("triple rate without loop");
  a_gate_cause: assert property (
    $changed(clk_gate_lo) || $changed(clk_gate_hi) |-> $past(wr) || $changed(stop_mode))
    else $error("gate moved without cause");
endmodule // pcg_props

// *** testbench/periph_clock_gating_test.sv ***
// bench joining controller and clock gating device, with an integer model of the registers
// assumes 50 MHz mclk; software port driven by non-blocking assignment after rising edges
module periph_clock_gating_test
  import pcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            mclk       = 1'b0;      // system clock
  logic            rst_n      = 1'b0;      // reset, active low
  logic [AW-1:0]   sw_addr    = 8'h00;     // software index
  logic [DW-1:0]   sw_wdata   = 16'h0000;  // software write data
  logic            sw_wr      = 1'b0;      // software write strobe
  logic            sw_rd      = 1'b0;      // software read strobe
  logic            pll_active = 1'b1;      // loop drives system clock
  logic [15:0]     irq_lo     = 16'h0000;  // low group interrupts
  logic [15:0]     irq_hi     = 16'h0000;  // high group interrupts
  logic [DW-1:0]   sw_rdata;
  logic [15:0]     periph_en_lo, periph_en_hi, clk_gate_lo, clk_gate_hi;
  logic [15:0]     access_ok_lo, access_ok_hi;
  logic            timer_fast, pwm_fast, two_wire_fast;
  int              failures = 0, check_count = 0, cycles = 0;
  int              m_pce_lo, m_pce_hi, m_sd, m_rate, m_run_lo, m_run_hi, m_stop;  // model
  localparam logic [7:0] ADDRS [9] = '{PCG_RATE_OFS, PCG_PCE_LO_OFS, PCG_PCE_HI_OFS,
    PCG_SD_LO_OFS, PCG_RUN_LO_OFS, PCG_RUN_HI_OFS, PCG_STOP_OFS, 8'h0F, 8'h23};

  always #10 mclk = ~mclk;
  pcg_if link ();
  pcg_clock_gate u_pcg_clock_gate (.mclk(mclk), .rst_n(rst_n), .bus(link.dev),
    .pll_active(pll_active), .irq_lo(irq_lo), .irq_hi(irq_hi), .clk_gate_lo(clk_gate_lo),
    .clk_gate_hi(clk_gate_hi), .access_ok_lo(access_ok_lo), .access_ok_hi(access_ok_hi),
    .timer_fast(timer_fast), .pwm_fast(pwm_fast), .two_wire_fast(two_wire_fast));
  pcg_controller u_pcg_controller (.mclk(mclk), .rst_n(rst_n), .bus(link.host),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .periph_en_lo(periph_en_lo), .periph_en_hi(periph_en_hi));
  pcg_props u_pcg_props (.mclk(mclk), .rst_n(rst_n), .wr(link.wr), .wr_addr(link.wr_addr),
    .wdata(link.wdata), .stop_req(link.stop_req), .stop_mode(link.stop_mode),
    .pll_active(pll_active), .irq_lo(irq_lo), .irq_hi(irq_hi), .clk_gate_lo(clk_gate_lo),
    .clk_gate_hi(clk_gate_hi), .access_ok_lo(access_ok_lo), .access_ok_hi(access_ok_hi),
    .timer_fast(timer_fast), .pwm_fast(pwm_fast), .two_wire_fast(two_wire_fast));

  // verdict and end of run
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard: the run needs about 800 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      print_verdict();
    end
  end
  // one comparison, reported at once on mismatch
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // expected gates: stop keeps only enabled and kept low clocks
  function automatic logic [15:0] gate_lo();
    return m_stop ? 16'(m_pce_lo & m_sd) : 16'(m_pce_lo);
  endfunction
  function automatic logic [15:0] gate_hi();
    return m_stop ? 16'h0000 : 16'(m_pce_hi);
  endfunction
  // expected read value; unmapped indices read zero
  function automatic logic [15:0] exp_reg(input logic [7:0] a);
    case (a)
      PCG_RATE_OFS:   return 16'(m_rate);
      PCG_PCE_LO_OFS: return 16'(m_pce_lo);
      PCG_PCE_HI_OFS: return 16'(m_pce_hi);
      PCG_SD_LO_OFS:  return 16'(m_sd);
      PCG_RUN_LO_OFS: return 16'(m_run_lo);
      PCG_RUN_HI_OFS: return 16'(m_run_hi);
      PCG_STOP_OFS:   return 16'(m_stop);
      default:        return 16'h0000;
    endcase
  endfunction
  // synchronous reset held three cycles; model cleared alongside
  task automatic do_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    {m_pce_lo, m_pce_hi, m_sd, m_rate, m_run_lo, m_run_hi, m_stop} = '0;
  endtask
  // one-cycle write; model keeps only writable bits
  task automatic sw_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge mclk);
    sw_wr <= 1'b0;
    case (a)
      PCG_RATE_OFS:   m_rate = d & PCG_RATE_MASK;
      PCG_PCE_LO_OFS: m_pce_lo = d & PCG_LO_MASK;
      PCG_PCE_HI_OFS: m_pce_hi = d & PCG_HI_MASK;
      PCG_SD_LO_OFS:  m_sd = d & PCG_LO_MASK;
      PCG_RUN_LO_OFS: m_run_lo = d & PCG_LO_MASK;
      PCG_RUN_HI_OFS: m_run_hi = d & PCG_HI_MASK;
      PCG_STOP_OFS:   if (d[STOP_REQ_BIT]) m_stop = 1;
      default:        ;
    endcase
  endtask
  // read every mapped index and two unmapped ones; data stand the cycle after the strobe
  task automatic read_all;
    foreach (ADDRS[i]) begin
      @(posedge mclk);
      sw_rd <= 1'b1;
      sw_addr <= ADDRS[i];
      @(posedge mclk);
      sw_rd <= 1'b0;
      #1;
      check(sw_rdata, exp_reg(ADDRS[i]));
    end
  endtask
  // let the write walk settle, then compare every gate, access, rate and enable output with the model
  task automatic compare_all;
    repeat (3) @(posedge mclk);
    #1;
    check(clk_gate_lo, gate_lo());
    check(clk_gate_hi, gate_hi());
    check(access_ok_lo, gate_lo());
    check(access_ok_hi, gate_hi());
    check({13'h0000, timer_fast, pwm_fast, two_wire_fast},
          pll_active ? 16'(m_rate >> 12) : 16'h0000);
    check(periph_en_lo, 16'(m_run_lo) & gate_lo());
    check(periph_en_hi, 16'(m_run_hi) & gate_hi());
  endtask
  // one-cycle interrupt; wakes only through a running low clock
  task automatic pulse_irq(input logic [15:0] lo, input logic [15:0] hi);
    @(posedge mclk);
    irq_lo <= lo;
    irq_hi <= hi;
    @(posedge mclk);
    irq_lo <= 16'h0000;
    irq_hi <= 16'h0000;
    if ((lo & gate_lo()) != 16'h0000) m_stop = 0;
  endtask

  // main sequence
  initial begin
    void'($urandom(32));
    do_reset();
    compare_all();
    read_all();
    $display("test reset_values done");
    for (int i = 0; i < 16; i++) begin
      sw_write(PCG_PCE_LO_OFS, 16'h0001 << i);
      sw_write(PCG_PCE_HI_OFS, 16'h0001 << i);
      compare_all();
    end
    $display("test walking_enables done");
    repeat (16) begin
      @(posedge mclk);
      pll_active <= 1'($urandom);
      sw_write(PCG_RUN_LO_OFS, 16'($urandom));
      sw_write(PCG_RUN_HI_OFS, 16'($urandom));
      sw_write(PCG_PCE_LO_OFS, 16'($urandom));
      sw_write(PCG_PCE_HI_OFS, 16'($urandom));
      sw_write(PCG_SD_LO_OFS, 16'($urandom));
      sw_write(PCG_RATE_OFS, 16'($urandom));
      compare_all();
      read_all();
    end
    $display("test random_config done");
    @(posedge mclk);
    pll_active <= 1'b1;
    sw_write(PCG_PCE_LO_OFS, 16'hFFFF);
    sw_write(PCG_PCE_HI_OFS, 16'hFFFF);
    sw_write(PCG_RUN_LO_OFS, 16'hFFFF);
    sw_write(PCG_RUN_HI_OFS, 16'hFFFF);
    sw_write(PCG_SD_LO_OFS, (16'($urandom) | 16'h0040) & 16'hFFFE);
    sw_write(PCG_STOP_OFS, 16'h0000);
    compare_all();
    sw_write(PCG_STOP_OFS, 16'h0001);
    compare_all();
    read_all();
    pulse_irq(16'h0001, 16'hFFFF);
    compare_all();
    pulse_irq(16'h0040, 16'h0000);
    compare_all();
    read_all();
    // a timer rate change holds the timer channels off for one cycle
    sw_write(PCG_RATE_OFS, 16'(m_rate) ^ 16'h4000);
    #1;
    check(periph_en_hi & TIMER_CH_MASK, 16'h0000);
    compare_all();
    // clearing enables drops the peripherals while their clocks still run
    sw_write(PCG_PCE_LO_OFS, 16'h0000);
    #1;
    check(periph_en_lo, 16'h0000);
    check(clk_gate_lo, PCG_LO_MASK);
    compare_all();
    $display("test stop_keep_wake done");
    sw_write(PCG_SD_LO_OFS, 16'h0000);
    sw_write(PCG_STOP_OFS, 16'h0001);
    pulse_irq(16'hFFFF, 16'hFFFF);
    compare_all();
    do_reset();
    compare_all();
    read_all();
    $display("test stop_all_reset done");
    print_verdict();
  end
endmodule // periph_clock_gating_test
